// ===== hw/ompc_consts.svh
// constants for the operating mode and power control block
// How it works
// - selector code 111 picks sub clock, slow mode
// - sub clock source by select bit, waits stable
// - codes 000 to 110 pick divided high clock
// - high clock restart shown on stable flags
// - halt with keeps 00 enters sleep
// - halt with keeps 01 keeps sub clock only
// - halt with keeps 11 keeps both clocks
// - halt with keeps 10 keeps high clock only
// - halt preserves memory, registers and ports
// - halt sets power-down, clears timeout flag
// - halt clears watchdog counter, enable governs counting
// - wake on port edge, interrupt, watchdog overflow
// - power-down flag cleared by power-up or clear-watchdog
// - watchdog wake sets timeout, resets pc and sp
// - per-pin port wake enable, resume after halt
// - disabled or stack-full interrupt resumes, stays pending
// - enabled interrupt with room gets normal response
// - interrupt already pending at halt cannot wake
// - run after wake only when high clock stable, or sub clock stable if halted from slow mode
// - peripheral clock follows system clock switch
// - separate settle counters per crystal
// - rc stable flag clears then sets on change
`ifndef OMPC_CONSTS_SVH
`define OMPC_CONSTS_SVH
`define OMPC_SEL_SUB      3'h7
`define OMPC_SEL_DIV_MAX  3'h6
`define OMPC_APB_SCC      12'h000
`define OMPC_APB_OSC      12'h004
`define OMPC_APB_STAT     12'h008
`define OMPC_APB_WAKE     12'h00c
`define OMPC_SETTLE_W     10
`define OMPC_HXT_SETTLE   10'h3ff
`define OMPC_HRC_SETTLE   10'h010
`define OMPC_LXT_SETTLE   10'h3ff
`define OMPC_LRC_SETTLE   10'h004
`define OMPC_RC_EN_RST    1'h1
`endif

// ===== hw/ompc_pkg.sv
// types for the operating mode and power control block
package ompc_pkg;
  typedef enum logic [2:0] {
    OMPC_FAST  = 3'b000,
    OMPC_SLOW  = 3'b001,
    OMPC_SLEEP = 3'b010,
    OMPC_IDLE_LOW_CLOCK_MODE = 3'b011,
    OMPC_IDLE_BOTH_CLOCK_MODE = 3'b100,
    OMPC_IDLE_HIGH_CLOCK_MODE = 3'b101,
    OMPC_WAKE  = 3'b110
  } ompc_mode_type;

  typedef struct packed {
    logic        paddr_ok;
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
  } ompc_apb_req_type;

  typedef struct packed {
    logic resume_next;  // continue after halt
    logic irq_vector;   // normal interrupt response
    logic pc_sp_reset;  // watchdog wake
  } ompc_wake_type;
endpackage : ompc_pkg

// ===== hw/ompc_top.sv
// operating mode, clock select and halt/wake control with apb registers
`include "ompc_consts.svh"
module ompc_top
  import ompc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        halt_exec,
  input  wire logic        clr_wdt_exec,
  input  wire logic        wdt_enable,
  input  wire logic        wdt_overflow,
  input  wire logic [7:0]  porta_pin,
  input  wire logic        irq_req,
  input  wire logic        irq_enable,
  input  wire logic        stack_full,
  output logic             wdt_clear,
  output logic             cpu_run,
  output logic             hold_state,
  output logic             hs_clk_on,
  output logic             ls_clk_on,
  output logic             sub_is_lxt,
  output logic             sysclk_is_sub,
  output logic [2:0]       hs_div_sel,
  output logic             periph_on_sub,
  output ompc_wake_type    wake_action,
  output logic             irq_pending
);
  // registers
  logic [2:0]    sysclk_select_ff;
  logic          hs_is_xtal_ff;
  logic          low_clock_source_sel_ff;
  logic          hs_osc_halt_keep_ff;
  logic          ls_osc_halt_keep_ff;
  logic          xtal_hs_en_ff;
  logic          rc_hs_en_ff;
  logic [1:0]    rc_hs_freq_ff;
  logic          lxt_en_ff;
  logic [7:0]    porta_wake_enable_ff;
  logic          power_down_flag_ff;
  logic          watchdog_timeout_flag_ff;
  ompc_mode_type mode_ff;
  ompc_mode_type run_mode_ff;
  logic [2:0]    sel_active_ff;
  logic          irq_pend_at_halt_ff;
  logic          irq_pending_ff;
  logic [7:0]    pa_s1_ff, pa_s2_ff, pa_s3_ff;
  logic [`OMPC_SETTLE_W-1:0] hxt_cnt_ff, hrc_cnt_ff, lxt_cnt_ff, lrc_cnt_ff;
  logic          hxt_stable_ff, hrc_stable_ff, lxt_stable_ff, lrc_stable_ff;
  logic [31:0]   prdata_ff;
  ompc_apb_req_type req;

  // settle counter step: restart on off, count to limit then stable
  function automatic logic [`OMPC_SETTLE_W-1:0] settle_next(
    input logic                      on,
    input logic                      restart,
    input logic [`OMPC_SETTLE_W-1:0] cnt,
    input logic [`OMPC_SETTLE_W-1:0] lim
  );
    if (!on || restart) begin
      settle_next = '0;
    end else if (cnt != lim) begin
      settle_next = cnt + 10'h001;
    end else begin
      settle_next = cnt;
    end
  endfunction : settle_next

  // sleep or any idle mode: cpu stopped, waiting for a wake event
  function automatic logic is_low_power(input ompc_mode_type m);
    is_low_power = (m == OMPC_SLEEP) || (m == OMPC_IDLE_LOW_CLOCK_MODE) ||
                   (m == OMPC_IDLE_BOTH_CLOCK_MODE) || (m == OMPC_IDLE_HIGH_CLOCK_MODE);
  endfunction : is_low_power

  // an enabled interrupt with stack room gets the normal response
  function automatic logic irq_serviced(
    input logic wake,
    input logic enable,
    input logic full
  );
    irq_serviced = wake && enable && !full;
  endfunction : irq_serviced

  // apb decode
  assign req.paddr    = paddr;
  assign req.pwrite   = pwrite;
  assign req.pwdata   = pwdata;
  assign req.paddr_ok = (paddr == `OMPC_APB_SCC) || (paddr == `OMPC_APB_OSC) ||
                        (paddr == `OMPC_APB_STAT) || (paddr == `OMPC_APB_WAKE);
  logic apb_acc, apb_wr;
  assign apb_acc = psel && penable;
  assign apb_wr  = apb_acc && req.pwrite && req.paddr_ok;
  assign pready  = 1'b1;
  assign pslverr = apb_acc && !req.paddr_ok;
  assign prdata  = prdata_ff;

  // halt sampling and wake decode
  logic hs_stable, ls_stable, in_low_power, pa_fall, irq_wake, wake_evt;
  assign hs_stable    = hs_is_xtal_ff ? hxt_stable_ff : hrc_stable_ff;
  assign ls_stable    = low_clock_source_sel_ff ? lxt_stable_ff : lrc_stable_ff;
  assign in_low_power = is_low_power(mode_ff);
  assign pa_fall  = |(pa_s3_ff & ~pa_s2_ff & porta_wake_enable_ff);
  assign irq_wake = irq_req && !irq_pend_at_halt_ff;
  assign wake_evt = in_low_power && (pa_fall || irq_wake || wdt_overflow);

  // halt only counts while the cpu runs
  logic halt_take;
  assign halt_take = halt_exec && cpu_run;

  // register writes from software
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sysclk_select_ff        <= 3'h0;
      hs_is_xtal_ff           <= 1'h0;
      low_clock_source_sel_ff <= 1'h0;
      hs_osc_halt_keep_ff     <= 1'h0;
      ls_osc_halt_keep_ff     <= 1'h0;
      xtal_hs_en_ff           <= 1'h0;
      rc_hs_en_ff             <= `OMPC_RC_EN_RST;
      rc_hs_freq_ff           <= 2'h0;
      lxt_en_ff               <= 1'h0;
      porta_wake_enable_ff    <= 8'h00;
    end else if (apb_wr && req.paddr == `OMPC_APB_SCC) begin
      sysclk_select_ff        <= req.pwdata[7:5];
      hs_is_xtal_ff           <= req.pwdata[3];
      low_clock_source_sel_ff <= req.pwdata[2];
      hs_osc_halt_keep_ff     <= req.pwdata[1];
      ls_osc_halt_keep_ff     <= req.pwdata[0];
    end else if (apb_wr && req.paddr == `OMPC_APB_OSC) begin
      rc_hs_en_ff   <= req.pwdata[0];
      rc_hs_freq_ff <= req.pwdata[3:2];
      xtal_hs_en_ff <= req.pwdata[8];
      lxt_en_ff     <= req.pwdata[16];
    end else if (apb_wr && req.paddr == `OMPC_APB_WAKE) begin
      porta_wake_enable_ff <= req.pwdata[7:0];
    end
  end

  // register reads
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata_ff <= 32'h0;
    end else if (psel && !penable) begin
      case (req.paddr)
        `OMPC_APB_SCC:  prdata_ff <= {24'h0, sysclk_select_ff, 1'b0, hs_is_xtal_ff,
                                      low_clock_source_sel_ff, hs_osc_halt_keep_ff,
                                      ls_osc_halt_keep_ff};
        `OMPC_APB_OSC:  prdata_ff <= {14'h0, lxt_stable_ff, lxt_en_ff, 6'h0,
                                      hxt_stable_ff, xtal_hs_en_ff, 4'h0,
                                      rc_hs_freq_ff, hrc_stable_ff, rc_hs_en_ff};
        `OMPC_APB_STAT: prdata_ff <= {24'h0, 1'b0, mode_ff, irq_pending_ff,
                                      lrc_stable_ff, watchdog_timeout_flag_ff,
                                      power_down_flag_ff};
        `OMPC_APB_WAKE: prdata_ff <= {24'h0, porta_wake_enable_ff};
        default:        prdata_ff <= 32'h0;
      endcase
    end
  end

  // port a two-flop sync plus edge history
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pa_s1_ff <= 8'hff;
      pa_s2_ff <= 8'hff;
      pa_s3_ff <= 8'hff;
    end else begin
      pa_s1_ff <= porta_pin;
      pa_s2_ff <= pa_s1_ff;
      pa_s3_ff <= pa_s2_ff;
    end
  end

  // oscillator settle counters, one per source
  logic hrc_chg, hs_need, ls_need;
  assign hrc_chg = apb_wr && req.paddr == `OMPC_APB_OSC &&
                   ((req.pwdata[0] && !rc_hs_en_ff) || req.pwdata[3:2] != rc_hs_freq_ff);
  assign hs_need = !in_low_power || (mode_ff != OMPC_SLEEP && mode_ff != OMPC_IDLE_LOW_CLOCK_MODE);
  assign ls_need = !in_low_power || (mode_ff != OMPC_SLEEP && mode_ff != OMPC_IDLE_HIGH_CLOCK_MODE);
  // high-speed crystal settle counter and stable flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hxt_cnt_ff    <= '0;
      hxt_stable_ff <= 1'h0;
    end else begin
      hxt_cnt_ff    <= settle_next(xtal_hs_en_ff && hs_need, 1'b0, hxt_cnt_ff,
                                   `OMPC_HXT_SETTLE);
      hxt_stable_ff <= hxt_cnt_ff == `OMPC_HXT_SETTLE;
    end
  end

  // high-speed rc settle counter and stable flag, restarted on a change
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrc_cnt_ff    <= '0;
      hrc_stable_ff <= 1'h0;
    end else begin
      hrc_cnt_ff    <= settle_next(rc_hs_en_ff && hs_need, hrc_chg, hrc_cnt_ff,
                                   `OMPC_HRC_SETTLE);
      hrc_stable_ff <= !hrc_chg && hrc_cnt_ff == `OMPC_HRC_SETTLE;
    end
  end

  // low-speed crystal settle counter and stable flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lxt_cnt_ff    <= '0;
      lxt_stable_ff <= 1'h0;
    end else begin
      lxt_cnt_ff    <= settle_next(lxt_en_ff && ls_need, 1'b0, lxt_cnt_ff,
                                   `OMPC_LXT_SETTLE);
      lxt_stable_ff <= lxt_cnt_ff == `OMPC_LXT_SETTLE;
    end
  end

  // low-speed rc settle counter and stable flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lrc_cnt_ff    <= '0;
      lrc_stable_ff <= 1'h0;
    end else begin
      lrc_cnt_ff    <= settle_next(ls_need, 1'b0, lrc_cnt_ff, `OMPC_LRC_SETTLE);
      lrc_stable_ff <= lrc_cnt_ff == `OMPC_LRC_SETTLE;
    end
  end

  // active clock select, switches to sub only once it is stable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_active_ff <= 3'h0;
    end else if (sysclk_select_ff == `OMPC_SEL_SUB) begin
      if (ls_stable) begin
        sel_active_ff <= `OMPC_SEL_SUB;
      end
    end else begin
      sel_active_ff <= sysclk_select_ff;
    end
  end

  // operating mode machine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_ff     <= OMPC_FAST;
      run_mode_ff <= OMPC_FAST;
    end else begin
      case (mode_ff)
        OMPC_FAST, OMPC_SLOW: begin
          if (halt_exec) begin
            run_mode_ff <= mode_ff;
            case ({hs_osc_halt_keep_ff, ls_osc_halt_keep_ff})
              2'b00:   mode_ff <= OMPC_SLEEP;
              2'b01:   mode_ff <= OMPC_IDLE_LOW_CLOCK_MODE;
              2'b11:   mode_ff <= OMPC_IDLE_BOTH_CLOCK_MODE;
              default: mode_ff <= OMPC_IDLE_HIGH_CLOCK_MODE;
            endcase
          end else begin
            mode_ff <= (sel_active_ff == `OMPC_SEL_SUB) ? OMPC_SLOW : OMPC_FAST;
          end
        end
        OMPC_SLEEP, OMPC_IDLE_LOW_CLOCK_MODE, OMPC_IDLE_BOTH_CLOCK_MODE, OMPC_IDLE_HIGH_CLOCK_MODE: begin
          if (wake_evt) begin
            mode_ff <= OMPC_WAKE;
          end
        end
        OMPC_WAKE: begin
          if (run_mode_ff == OMPC_SLOW ? ls_stable : hs_stable) begin
            mode_ff <= run_mode_ff;
          end
        end
        default: mode_ff <= OMPC_FAST;
      endcase
    end
  end

  // wake cause latched for the cpu
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake_action <= '0;
    end else if (wake_evt) begin
      wake_action.pc_sp_reset <= wdt_overflow;
      wake_action.irq_vector  <= !wdt_overflow &&
                                 irq_serviced(irq_wake, irq_enable, stack_full);
      wake_action.resume_next <= !wdt_overflow &&
                                 !irq_serviced(irq_wake, irq_enable, stack_full);
    end else if (mode_ff != OMPC_WAKE) begin
      wake_action <= '0;
    end
  end

  // interrupt request seen at halt, blocks it as a wake source
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_pend_at_halt_ff <= 1'h0;
    end else if (halt_take) begin
      irq_pend_at_halt_ff <= irq_req;
    end
  end

  // interrupt held pending until enabled with stack room
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_pending_ff <= 1'h0;
    end else if (irq_req && (!irq_enable || stack_full)) begin
      irq_pending_ff <= 1'h1;
    end else if (irq_serviced(1'b1, irq_enable, stack_full)) begin
      irq_pending_ff <= 1'h0;
    end
  end

  // power-down flag: halt sets, clear-watchdog clears, set wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_down_flag_ff <= 1'h0;
    end else if (halt_take) begin
      power_down_flag_ff <= 1'h1;
    end else if (clr_wdt_exec) begin
      power_down_flag_ff <= 1'h0;
    end
  end

  // timeout flag: watchdog wake sets, halt clears
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      watchdog_timeout_flag_ff <= 1'h0;
    end else if (in_low_power && wdt_overflow) begin
      watchdog_timeout_flag_ff <= 1'h1;
    end else if (halt_take) begin
      watchdog_timeout_flag_ff <= 1'h0;
    end
  end

  // clock and cpu control outputs
  assign wdt_clear     = halt_take || clr_wdt_exec;
  assign cpu_run       = (mode_ff == OMPC_FAST) || (mode_ff == OMPC_SLOW);
  assign hold_state    = in_low_power || mode_ff == OMPC_WAKE;
  assign hs_clk_on     = hs_need;
  assign ls_clk_on     = ls_need || wdt_enable;
  assign sub_is_lxt    = low_clock_source_sel_ff;
  assign sysclk_is_sub = sel_active_ff == `OMPC_SEL_SUB;
  assign hs_div_sel    = sysclk_is_sub ? 3'h0 : sel_active_ff;
  assign periph_on_sub = sysclk_is_sub;
  assign irq_pending   = irq_pending_ff;
endmodule : ompc_top

// ===== verif/ompc_assertions.sv
// checker for halt, wake and clock selection at the block's ports
module ompc_checker
  import ompc_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          rst,
  input wire logic          halt_exec,
  input wire logic          clr_wdt_exec,
  input wire logic          wdt_overflow,
  input wire logic          wdt_clear,
  input wire logic          cpu_run,
  input wire logic          hold_state,
  input wire logic          hs_clk_on,
  input wire logic          ls_clk_on,
  input wire logic          sysclk_is_sub,
  input wire logic          periph_on_sub,
  input wire ompc_wake_type wake_action
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // watchdog clear only from halt or the clear instruction
  a_halt_clears_wdt: assert property (halt_exec && cpu_run |-> wdt_clear)
    else $error("halt did not clear the watchdog");
  a_quiet_wdt_clear: assert property (!halt_exec && !clr_wdt_exec |-> !wdt_clear)
    else $error("watchdog cleared with no cause");
  // halt stops execution on the next edge, and it stays stopped
  a_halt_stops_cpu: assert property (halt_exec && cpu_run |=> !cpu_run && hold_state)
    else $error("halt did not stop execution");
  a_held_no_run: assert property (hold_state |-> !cpu_run)
    else $error("execution while held");
  // watchdog wake marks a pc and sp reset
  a_wdt_wake: assert property (hold_state && wake_action == 3'h0 && wdt_overflow
    |-> ##[1:2] wake_action.pc_sp_reset)
    else $error("watchdog wake not reported");
  a_wake_cause: assert property ($fell(hold_state) |-> $past(wake_action) != 3'h0)
    else $error("left low power with no wake event");
  // clock sources behind the running modes
  a_periph_follows: assert property (periph_on_sub == sysclk_is_sub)
    else $error("peripheral clock not following system clock");
  a_fast_hs_on: assert property (cpu_run && !sysclk_is_sub |-> hs_clk_on)
    else $error("fast mode running without high clock");
  a_slow_ls_on: assert property (cpu_run && sysclk_is_sub |-> ls_clk_on)
    else $error("slow mode running without sub clock");

  c_halt: cover property (halt_exec && cpu_run);
  c_wdt_wake: cover property (wake_action.pc_sp_reset);
  c_slow: cover property (cpu_run && sysclk_is_sub);
  c_resume: cover property (wake_action.resume_next);
endmodule : ompc_checker

bind ompc_top ompc_checker u_chk (.*);

// ===== verif/operating_mode_power_control_tb.sv
// self-checking bench for the operating mode and power control block
`include "ompc_consts.svh"
module operating_mode_power_control_tb
  import ompc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0, prdata, q;
  logic          halt_exec = 1'b0, clr_wdt_exec = 1'b0, wdt_enable = 1'b1, wdt_overflow = 1'b0;
  logic [7:0]    porta_pin = 8'hff;
  logic          irq_req = 1'b0, irq_enable = 1'b0, stack_full = 1'b0, e;
  logic          pready, pslverr, wdt_clear, cpu_run, hold_state, hs_clk_on, ls_clk_on;
  logic          sub_is_lxt, sysclk_is_sub, periph_on_sub, irq_pending;
  logic [2:0]    hs_div_sel;
  ompc_wake_type wake_action, acc;
  int            bad_count = 0, num_checks = 0, cycles = 0, waited = 0;
  logic [2:0]    modes [4] = '{OMPC_SLEEP, OMPC_IDLE_LOW_CLOCK_MODE, OMPC_IDLE_HIGH_CLOCK_MODE, OMPC_IDLE_BOTH_CLOCK_MODE};

  ompc_top uut (.*);

  // clock and hang guard
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // wait for execution to resume, collecting the wake action
  task automatic wake_wait();
    acc = '0;
    waited = 0;
    while (waited < 3000 && cpu_run !== 1'b1) begin
      @(posedge sys_clk);
      acc = acc | wake_action;
      waited++;
    end
    chk(cpu_run, 1);
  endtask : wake_wait

  task automatic do_halt(input logic [1:0] keep);
    apb(1, `OMPC_APB_SCC, {30'h0, keep});
    @(posedge sys_clk);
    halt_exec <= 1'b1;
    @(posedge sys_clk);
    halt_exec <= 1'b0;
    chk(wdt_clear, 1);
    @(posedge sys_clk);
    chk({cpu_run, hold_state}, 2'b01);
  endtask : do_halt

  task automatic t_clock_select();
    apb(0, `OMPC_APB_SCC, 0);
    chk(q, 0);
    for (int c = 0; c < 7; c++) begin
      apb(1, `OMPC_APB_SCC, c << 5);
      repeat (2) @(posedge sys_clk);
      chk({sysclk_is_sub, hs_div_sel}, c);
    end
    apb(1, `OMPC_APB_SCC, 32'he0);
    for (int i = 0; i < 100 && sysclk_is_sub !== 1'b1; i++) @(posedge sys_clk);
    chk({sysclk_is_sub, periph_on_sub, sub_is_lxt}, 3'b110);
    apb(0, `OMPC_APB_STAT, 0);
    chk(q[6:4], 1);
    apb(1, `OMPC_APB_SCC, 0);
    repeat (2) @(posedge sys_clk);
    chk(sysclk_is_sub, 0);
    // crystal sub clock switches only once its own counter settles
    apb(1, `OMPC_APB_OSC, 32'h10001);
    apb(1, `OMPC_APB_SCC, 32'he4);
    repeat (20) @(posedge sys_clk);
    chk(sysclk_is_sub, 0);
    for (int i = 0; i < 1200 && sysclk_is_sub !== 1'b1; i++) @(posedge sys_clk);
    chk({sysclk_is_sub, sub_is_lxt}, 2'b11);
    apb(0, `OMPC_APB_OSC, 0);
    chk(q, 32'h30003);
    // a new rc frequency drops its stable flag until it settles again
    apb(1, `OMPC_APB_OSC, 32'h10005);
    apb(0, `OMPC_APB_OSC, 0);
    chk(q[1], 0);
    repeat (20) @(posedge sys_clk);
    apb(0, `OMPC_APB_OSC, 0);
    chk(q, 32'h30007);
    apb(1, `OMPC_APB_SCC, 0);
  endtask : t_clock_select

  task automatic t_halt_modes();
    for (int k = 0; k < 4; k++) begin
      wdt_enable <= k[0];
      do_halt(k[1:0]);
      chk({hs_clk_on, ls_clk_on}, k);
      apb(0, `OMPC_APB_STAT, 0);
      chk({q[6:4], q[1:0]}, {modes[k], 2'b01});
      @(posedge sys_clk);
      wdt_overflow <= 1'b1;
      @(posedge sys_clk);
      wdt_overflow <= 1'b0;
      wake_wait();
      chk(acc, 3'b001);
      chk(waited > `OMPC_HRC_SETTLE, !k[1]);
      apb(0, `OMPC_APB_STAT, 0);
      chk({q[6:4], q[1:0]}, 5'b00011);
      apb(0, `OMPC_APB_SCC, 0);
      chk(q, k);
      @(posedge sys_clk);
      clr_wdt_exec <= 1'b1;
      @(posedge sys_clk);
      clr_wdt_exec <= 1'b0;
      apb(0, `OMPC_APB_STAT, 0);
      chk(q[0], 0);
    end
  endtask : t_halt_modes

  task automatic t_port_wake();
    apb(1, `OMPC_APB_WAKE, 1);
    do_halt(0);
    porta_pin <= 8'hfd;
    repeat (10) @(posedge sys_clk);
    chk(hold_state, 1);
    porta_pin <= 8'hfc;
    wake_wait();
    chk(acc, 3'b100);
    porta_pin <= 8'hff;
  endtask : t_port_wake

  task automatic t_irq_wake();
    for (int i = 0; i < 3; i++) begin
      irq_enable <= (i != 0);
      stack_full <= (i == 1);
      do_halt(0);
      irq_req <= 1'b1;
      wake_wait();
      chk(acc, (i == 2) ? 3'b010 : 3'b100);
      if (i != 2) chk(irq_pending, 1);
      irq_req <= 1'b0;
      irq_enable <= 1'b1;
      stack_full <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    // a request already raised at halt cannot wake
    irq_req <= 1'b1;
    do_halt(0);
    repeat (20) @(posedge sys_clk);
    chk(hold_state, 1);
    wdt_overflow <= 1'b1;
    @(posedge sys_clk);
    wdt_overflow <= 1'b0;
    wake_wait();
    chk(acc, 3'b001);
    irq_req <= 1'b0;
  endtask : t_irq_wake

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    chk(cpu_run, 1);
    t_clock_select();
    t_halt_modes();
    t_port_wake();
    t_irq_wake();
    apb(0, 12'h010, 0);
    chk({31'h0, e}, 1);
    chk(q, 0);
    report_and_stop();
  end
endmodule : operating_mode_power_control_tb
